/* src/idpad_cfg.svh */
// Constants for the identification code and port alias decoder block
`ifndef IDPAD_CFG_SVH
`define IDPAD_CFG_SVH

`define IDPAD_OFS_ID0 8'hF0
`define IDPAD_OFS_ID1 8'hF1
`define IDPAD_OFS_ID2 8'hF2
`define IDPAD_OFS_ID3 8'hF3
`define IDPAD_OFS_ID4 8'hF4
`define IDPAD_OFS_ID5 8'hF5
`define IDPAD_OFS_ALIAS0 8'hF8
`define IDPAD_OFS_ALIAS1 8'hF9
`define IDPAD_OFS_PORT_SEL 8'h4C
`define IDPAD_ALIAS_RESET 7'h00
`define IDPAD_PORT_SEL_RESET 8'h00
`define IDPAD_ALIAS_MSB 7
`define IDPAD_ALIAS_LSB 1
`define IDPAD_ZERO_ADDR 7'h00
`define IDPAD_ZERO_BYTE 8'h00
`define IDPAD_PSEL_P1_BIT 1
`define IDPAD_PORT0 2'h0
`define IDPAD_PORT1 2'h1

`endif

/* src/idpad_pkg.sv */
// Types for the identification code and port alias decoder block
package idpad_pkg;

	typedef enum logic [3:0]
	{
		IDPAD_TGT_NONE = 4'h1,
		IDPAD_TGT_MAIN = 4'h2,
		IDPAD_TGT_ALIAS0 = 4'h4,
		IDPAD_TGT_ALIAS1 = 4'h8
	} idpad_target_type;

endpackage : idpad_pkg

/* src/idpad_alias_match.sv */
// Alias address comparator for one receive port
`timescale 1ns/100ps
`include "idpad_cfg.svh"
module idpad_alias_match
	import idpad_pkg::*;
(
	input wire logic [6:0] alias_in,
	input wire logic [6:0] addr_in,
	output logic hit_out
);
	// A zero alias disables the decoder, so address zero never matches here
	assign hit_out = (alias_in != `IDPAD_ZERO_ADDR) && (alias_in == addr_in);
endmodule : idpad_alias_match

/* src/idpad_regs.sv */
// Identification code registers, port select and receive port alias decoder
`timescale 1ns/100ps
`include "idpad_cfg.svh"
module idpad_regs
	import idpad_pkg::*;
#(
	parameter logic [7:0] ID_BYTE0 = 8'hA1, // Arbitrary identification values
	parameter logic [7:0] ID_BYTE1 = 8'hA2,
	parameter logic [7:0] ID_BYTE2 = 8'hA3,
	parameter logic [7:0] ID_BYTE3 = 8'hA4,
	parameter logic [7:0] ID_BYTE4 = 8'hA5,
	parameter logic [7:0] ID_BYTE5 = 8'hA6,
	parameter logic [6:0] MAIN_ADDR = 7'h3D // Arbitrary primary target address
)
(
	input wire logic mclk_in,
	input wire logic rst_in,
	input wire logic txn_start_in,
	input wire logic [6:0] txn_addr_in,
	input wire logic wr_en_in,
	input wire logic rd_en_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic [7:0] wr_data_in,
	output logic [7:0] rd_data_out,
	output logic txn_ack_out,
	output logic [1:0] port_sel_out,
	output logic port_access_out,
	output logic [6:0] port0_alias_out,
	output logic [6:0] port1_alias_out
);
	// ==========================================================
	// Address decode
	logic [6:0] alias0_reg;
	logic [6:0] alias1_reg;
	logic [7:0] psel_reg;
	idpad_target_type tgt_reg;
	idpad_target_type tgt_next;
	logic hit0;
	logic hit1;
	logic hit_main;
	logic [7:0] rd_data_reg;
	logic [7:0] rd_mux;
	logic txn_ack_reg;
	logic [1:0] port_sel_reg;
	logic [1:0] port_sel_next;
	logic port_access_reg;
	logic sel_valid;
	logic wr_alias0;
	logic wr_alias1;
	logic wr_psel;
	logic rd_take;
	logic [6:0] wr_field;

	idpad_alias_match u_m0
	(
		.alias_in(alias0_reg),
		.addr_in(txn_addr_in),
		.hit_out(hit0)
	);

	idpad_alias_match u_m1
	(
		.alias_in(alias1_reg),
		.addr_in(txn_addr_in),
		.hit_out(hit1)
	);

	assign hit_main = (txn_addr_in == MAIN_ADDR);
	// Alias wins over the main address if software programs the same value
	assign tgt_next = hit0 ? IDPAD_TGT_ALIAS0 :
		hit1 ? IDPAD_TGT_ALIAS1 :
		hit_main ? IDPAD_TGT_MAIN : IDPAD_TGT_NONE;
	assign sel_valid = (tgt_reg != IDPAD_TGT_NONE);
	// Port steering: alias fixes the port, otherwise the page register does
	assign port_sel_next = (tgt_reg == IDPAD_TGT_ALIAS0) ? `IDPAD_PORT0 :
		(tgt_reg == IDPAD_TGT_ALIAS1) ? `IDPAD_PORT1 :
		{1'b0, psel_reg[`IDPAD_PSEL_P1_BIT]};
	// Accesses count only once a start has latched a target; the rest are refused
	assign rd_take = rd_en_in && sel_valid;
	assign wr_field = wr_data_in[`IDPAD_ALIAS_MSB:`IDPAD_ALIAS_LSB];
	assign wr_alias0 = wr_en_in && sel_valid && (reg_addr_in == `IDPAD_OFS_ALIAS0);
	assign wr_alias1 = wr_en_in && sel_valid && (reg_addr_in == `IDPAD_OFS_ALIAS1);
	assign wr_psel = wr_en_in && sel_valid && (reg_addr_in == `IDPAD_OFS_PORT_SEL);

	// ==========================================================
	// Read mux; shared registers stay visible under every target
	always_comb
	begin
		case (reg_addr_in)
			`IDPAD_OFS_ID0: rd_mux = ID_BYTE0;
			`IDPAD_OFS_ID1: rd_mux = ID_BYTE1;
			`IDPAD_OFS_ID2: rd_mux = ID_BYTE2;
			`IDPAD_OFS_ID3: rd_mux = ID_BYTE3;
			`IDPAD_OFS_ID4: rd_mux = ID_BYTE4;
			`IDPAD_OFS_ID5: rd_mux = ID_BYTE5;
			`IDPAD_OFS_ALIAS0: rd_mux = {alias0_reg, 1'b0};
			`IDPAD_OFS_ALIAS1: rd_mux = {alias1_reg, 1'b0};
			`IDPAD_OFS_PORT_SEL: rd_mux = psel_reg;
			default: rd_mux = `IDPAD_ZERO_BYTE;
		endcase
	end

	// ==========================================================
	// Registers
	always_ff @(posedge mclk_in or posedge rst_in)
	begin
		if (rst_in)
			tgt_reg <= IDPAD_TGT_NONE;
		else if (txn_start_in)
			tgt_reg <= tgt_next;
	end

	// ID offsets have no write path at all, so writes there change nothing
	always_ff @(posedge mclk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			alias0_reg <= `IDPAD_ALIAS_RESET;
			alias1_reg <= `IDPAD_ALIAS_RESET;
			psel_reg <= `IDPAD_PORT_SEL_RESET;
		end
		else
		begin
			if (wr_alias0)
				alias0_reg <= wr_field;
			if (wr_alias1)
				alias1_reg <= wr_field;
			if (wr_psel)
				psel_reg <= wr_data_in;
		end
	end

	always_ff @(posedge mclk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			rd_data_reg <= `IDPAD_ZERO_BYTE;
			txn_ack_reg <= 1'b0;
			port_sel_reg <= `IDPAD_PORT0;
			port_access_reg <= 1'b0;
		end
		else
		begin
			if (rd_take)
				rd_data_reg <= rd_mux;
			txn_ack_reg <= txn_start_in && (tgt_next != IDPAD_TGT_NONE);
			port_sel_reg <= port_sel_next;
			port_access_reg <= sel_valid;
		end
	end

	assign rd_data_out = rd_data_reg;
	assign txn_ack_out = txn_ack_reg;
	assign port_sel_out = port_sel_reg;
	assign port_access_out = port_access_reg;
	assign port0_alias_out = alias0_reg;
	assign port1_alias_out = alias1_reg;

	// ==========================================================
	// Checks
	// Read checks look one edge after the strobe, once the byte has been latched
	chk_alias0_route: assert property (@(posedge mclk_in) disable iff (rst_in)
		tgt_reg == IDPAD_TGT_ALIAS0 |=> port_sel_out == `IDPAD_PORT0)
		else $error("alias0 not routed");
	chk_alias1_route: assert property (@(posedge mclk_in) disable iff (rst_in)
		tgt_reg == IDPAD_TGT_ALIAS1 |=> port_sel_out == `IDPAD_PORT1)
		else $error("alias1 not routed");
	chk_zero_alias0: assert property (@(posedge mclk_in) disable iff (rst_in)
		txn_start_in && alias0_reg == `IDPAD_ZERO_ADDR |=> tgt_reg != IDPAD_TGT_ALIAS0)
		else $error("zero alias0 hit");
	chk_zero_alias1: assert property (@(posedge mclk_in) disable iff (rst_in)
		txn_start_in && alias1_reg == `IDPAD_ZERO_ADDR |=> tgt_reg != IDPAD_TGT_ALIAS1)
		else $error("zero alias1 hit");
	chk_id_first: assert property (@(posedge mclk_in) disable iff (rst_in)
		rd_take && reg_addr_in == `IDPAD_OFS_ID0 |=> rd_data_out == ID_BYTE0)
		else $error("id0 wrong");
	chk_id_second: assert property (@(posedge mclk_in) disable iff (rst_in)
		rd_take && reg_addr_in == `IDPAD_OFS_ID1 |=> rd_data_out == ID_BYTE1)
		else $error("id1 wrong");
	chk_id_third: assert property (@(posedge mclk_in) disable iff (rst_in)
		rd_take && reg_addr_in == `IDPAD_OFS_ID2 |=> rd_data_out == ID_BYTE2)
		else $error("id2 wrong");
	chk_id_fourth: assert property (@(posedge mclk_in) disable iff (rst_in)
		rd_take && reg_addr_in == `IDPAD_OFS_ID3 |=> rd_data_out == ID_BYTE3)
		else $error("id3 wrong");
	chk_id_fifth: assert property (@(posedge mclk_in) disable iff (rst_in)
		rd_take && reg_addr_in == `IDPAD_OFS_ID4 |=> rd_data_out == ID_BYTE4)
		else $error("id4 wrong");
	chk_id_last: assert property (@(posedge mclk_in) disable iff (rst_in)
		rd_take && reg_addr_in == `IDPAD_OFS_ID5 |=> rd_data_out == ID_BYTE5)
		else $error("id5 wrong");
	chk_alias_write: assert property (@(posedge mclk_in) disable iff (rst_in)
		wr_alias0 |=> alias0_reg == $past(wr_field))
		else $error("alias0 write");
	chk_alias1_write: assert property (@(posedge mclk_in) disable iff (rst_in)
		wr_alias1 |=> alias1_reg == $past(wr_field))
		else $error("alias1 write");
	chk_alias0_bit0: assert property (@(posedge mclk_in) disable iff (rst_in)
		rd_take && reg_addr_in == `IDPAD_OFS_ALIAS0 |=> rd_data_out[0] == 1'b0)
		else $error("alias0 bit0 set");
	chk_alias_bit0: assert property (@(posedge mclk_in) disable iff (rst_in)
		rd_take && reg_addr_in == `IDPAD_OFS_ALIAS1 |=> rd_data_out[0] == 1'b0)
		else $error("alias1 bit0 set");
	chk_page_route: assert property (@(posedge mclk_in) disable iff (rst_in)
		tgt_reg == IDPAD_TGT_MAIN |=> port_sel_out == {1'b0, $past(psel_reg[`IDPAD_PSEL_P1_BIT])})
		else $error("page route");
	chk_shared_read: assert property (@(posedge mclk_in) disable iff (rst_in)
		tgt_reg == IDPAD_TGT_ALIAS0 && rd_take && reg_addr_in == `IDPAD_OFS_ALIAS1 |=>
		rd_data_out == {$past(alias1_reg), 1'b0})
		else $error("shared read under alias");
	chk_alias0_ack: assert property (@(posedge mclk_in) disable iff (rst_in)
		txn_start_in && hit0 |=> txn_ack_out)
		else $error("alias0 not acknowledged");
	chk_alias1_ack: assert property (@(posedge mclk_in) disable iff (rst_in)
		txn_start_in && hit1 |=> txn_ack_out)
		else $error("alias1 not acknowledged");
	chk_main_ack: assert property (@(posedge mclk_in) disable iff (rst_in)
		txn_start_in && hit_main |=> txn_ack_out)
		else $error("main not acknowledged");
	chk_ack_none: assert property (@(posedge mclk_in) disable iff (rst_in)
		txn_start_in && !hit0 && !hit1 && !hit_main |=> !txn_ack_out)
		else $error("unmatched address acknowledged");
	chk_refused_read: assert property (@(posedge mclk_in) disable iff (rst_in)
		rd_en_in && !sel_valid |=> $stable(rd_data_out))
		else $error("refused read changed data");

	// ==========================================================
	// Cover points
	cov_alias0_hit: cover property (@(posedge mclk_in) disable iff (rst_in) txn_start_in && hit0);
	cov_alias1_hit: cover property (@(posedge mclk_in) disable iff (rst_in) txn_start_in && hit1);
	cov_main_hit: cover property (@(posedge mclk_in) disable iff (rst_in) txn_start_in && hit_main);
	cov_page_select: cover property (@(posedge mclk_in) disable iff (rst_in)
		tgt_reg == IDPAD_TGT_MAIN && psel_reg[`IDPAD_PSEL_P1_BIT]);
endmodule : idpad_regs

/* tb/idpad_host_model.sv */
// Host controller model that issues decoder transactions
`timescale 1ns/100ps
module idpad_host_model
(
	input wire logic mclk_in,
	input wire logic ack_in,
	input wire logic [7:0] rd_data_in,
	output logic start_out,
	output logic [6:0] addr_out,
	output logic wr_out,
	output logic rd_out,
	output logic [7:0] reg_out,
	output logic [7:0] data_out
);
	initial
	begin
		{start_out, wr_out, rd_out, addr_out, reg_out, data_out} = 26'h0;
	end
	// Main address for paged access, or an alias to skip paging
	task start(input logic [6:0] a, output logic ack);
		@(negedge mclk_in);
		start_out = 1'h1;
		addr_out = a;
		@(negedge mclk_in);
		start_out = 1'h0;
		addr_out = ~a;
		ack = ack_in;
		@(negedge mclk_in);
	endtask : start
	// Released register and data lines show the inverse, strobes drop to zero, so a stale value cannot pass
	task xfer(input logic w, input logic [7:0] r, input logic [7:0] d, output logic [7:0] q);
		@(negedge mclk_in);
		wr_out = w;
		rd_out = ~w;
		reg_out = r;
		data_out = d;
		@(negedge mclk_in);
		{wr_out, rd_out} = 2'h0;
		reg_out = ~r;
		data_out = ~d;
		q = rd_data_in;
	endtask : xfer
endmodule : idpad_host_model

/* tb/test_id_code_and_port_alias_decoder.sv */
// Self-checking bench for the identification code and alias decoder
`timescale 1ns/100ps
module test_id_code_and_port_alias_decoder;
	// Arbitrary identification values
	localparam logic [7:0] ID [6] = '{8'h1A, 8'h2B, 8'h3C, 8'h4D, 8'h5E, 8'h6F};
	localparam logic [6:0] MAIN = 7'h3D;
	logic mclk_in = 1'h0;
	logic rst_in = 1'h1;
	logic start, wr, rd, ack, access, b;
	logic [6:0] addr, al0, al1;
	logic [7:0] ra, wd, rdata, q;
	logic [1:0] psel;
	int fails = 0;
	int checks = 0;
	always #50 mclk_in = ~mclk_in;
	idpad_regs #(.ID_BYTE0(ID[0]), .ID_BYTE1(ID[1]), .ID_BYTE2(ID[2]), .ID_BYTE3(ID[3]), .ID_BYTE4(ID[4]),
		.ID_BYTE5(ID[5]), .MAIN_ADDR(MAIN)) DUT (.mclk_in(mclk_in), .rst_in(rst_in), .txn_start_in(start),
		.txn_addr_in(addr), .wr_en_in(wr), .rd_en_in(rd), .reg_addr_in(ra), .wr_data_in(wd),
		.rd_data_out(rdata), .txn_ack_out(ack), .port_sel_out(psel), .port_access_out(access),
		.port0_alias_out(al0), .port1_alias_out(al1));
	idpad_host_model host (.mclk_in(mclk_in), .ack_in(ack), .rd_data_in(rdata), .start_out(start),
		.addr_out(addr), .wr_out(wr), .rd_out(rd), .reg_out(ra), .data_out(wd));
	task check(input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp)
		begin
			fails++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task final_report;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : final_report
	task go(input logic [6:0] a, input logic exp);
		host.start(a, b);
		check({7'h00, b}, {7'h00, exp});
	endtask : go
	task rdc(input logic [7:0] r, input logic [7:0] exp);
		host.xfer(1'h0, r, 8'h00, q);
		check(q, exp);
	endtask : rdc
	// ========
	// Tests
	initial
	begin
		repeat (12) @(posedge mclk_in);
		@(negedge mclk_in);
		rst_in = 1'h0;
		go(MAIN, 1'h1);
		for (int i = 0; i < 6; i++)
		begin
			host.xfer(1'h1, 8'hF0 + 8'(i), 8'hFF, q);
			rdc(8'hF0 + 8'(i), ID[i]);
		end
		rdc(8'hF8, 8'h00);
		rdc(8'hF9, 8'h00);
		go(7'h00, 1'h0);
		go(7'h11, 1'h0);
		$display("test identification and reset done");
		go(MAIN, 1'h1);
		host.xfer(1'h1, 8'hF8, 8'h23, q);
		host.xfer(1'h1, 8'hF9, 8'h45, q);
		rdc(8'hF8, 8'h22);
		check({al0, 1'h0}, 8'h22);
		check({al1, 1'h0}, 8'h44);
		go(7'h11, 1'h1);
		check({access, 5'h00, psel}, 8'h80);
		rdc(8'hF9, 8'h44);
		rdc(8'hF3, ID[3]);
		go(7'h22, 1'h1);
		check({access, 5'h00, psel}, 8'h81);
		$display("test alias decode done");
		go(MAIN, 1'h1);
		host.xfer(1'h1, 8'h4C, 8'h02, q);
		go(MAIN, 1'h1);
		check({6'h00, psel}, 8'h01);
		go(7'h11, 1'h1);
		check({6'h00, psel}, 8'h00);
		host.xfer(1'h1, 8'hF8, 8'h00, q);
		go(7'h11, 1'h0);
		check({7'h00, access}, 8'h00);
		rdc(8'hF9, ID[3]);
		host.xfer(1'h1, 8'hF9, 8'h01, q);
		go(7'h22, 1'h1);
		host.xfer(1'h1, 8'hF9, 8'h01, q);
		go(7'h22, 1'h0);
		go(MAIN, 1'h1);
		rdc(8'hF9, 8'h00);
		$display("test paging and disable done");
		final_report();
	end
	// Tests need about 100 cycles; allow 4000
	initial
	begin
		#400000;
		fails++;
		final_report();
	end
endmodule : test_id_code_and_port_alias_decoder
